// >>> verilog/evt_consts.vh
// Register offsets, field positions, mode codes and reset values of the event detector
`ifndef EVT_CONSTS_VH
`define EVT_CONSTS_VH

`define A_CTRL 8'h00
`define A_SEL 8'h04
`define A_SEQ 8'h08
`define A_SUB_LO 8'h0C
`define A_SUB_HI 8'h10
`define A_EV_IDX 8'h14
`define A_EV_CFG 8'h18
`define A_EV_LO 8'h1C
`define A_EV_HI 8'h20
`define A_HITS 8'h24
`define A_STAT 8'h28
`define A_INT_ST 8'h2C
`define A_INT_MASK 8'h30
`define A_TRANS 8'h34

`define CTRL_ARM 0
`define CTRL_MODE_LO 1
`define CTRL_FINAL_LO 4
`define CTRL_HALT 7
`define CTRL_TRACE 8
`define CTRL_PERF 9
`define CTRL_W 10
`define CTRL_RST 10'h000

`define MODE_OR 3'h0
`define MODE_ACC 3'h1
`define MODE_SIM 3'h2
`define MODE_SUB 3'h3
`define MODE_SEQ 3'h4
`define MODE_FSM 3'h5

`define CFG_TYPE_LO 0
`define CFG_RANGE 2
`define CFG_RD 3
`define CFG_WR 4
`define CFG_IRQ_IN 5
`define CFG_IRQ_OUT 6
`define CFG_TRIG_LVL 7
`define CFG_EN 8
`define CFG_W 9

`define TYPE_FETCH 2'h0
`define TYPE_DATA 2'h1
`define TYPE_IRQ 2'h2
`define TYPE_TRIG 2'h3

`define TR_STATE_LO 0
`define TR_EV_LO 3
`define TR_NEXT_LO 7
`define TR_EN 10
`define TR_W 8

`define INT_COND 0
`define INT_HIT 1
`define INT_W 2

`endif

// >>> verilog/event_match.v
// One event comparator: fetch, data access, interrupt or trigger match, registered hit
`timescale 1ns/100ps
`include "evt_consts.vh"
module event_match #(
  parameter AW = 24
) (
  input wire clk_sys,
  input wire rst_n,
  input wire armed,
  input wire [`CFG_W-1:0] cfg,
  input wire [AW-1:0] lo,
  input wire [AW-1:0] hi,
  input wire exec_valid,
  input wire [AW-1:0] exec_addr,
  input wire bus_valid,
  input wire bus_write,
  input wire [AW-1:0] bus_addr,
  input wire irq_enter,
  input wire irq_return,
  input wire trig_level,
  output reg hit_q
);
  wire [1:0] typ = cfg[`CFG_TYPE_LO+1:`CFG_TYPE_LO];
  wire in_rng = (bus_addr >= lo) && (bus_addr <= hi);
  wire addr_ok = cfg[`CFG_RANGE] ? in_rng : (bus_addr == lo);
  wire dir_ok = bus_write ? cfg[`CFG_WR] : cfg[`CFG_RD];
  reg hit_d;

  always @*
  begin
    case (typ)
      // Only executed instructions count, prefetch traffic never reaches exec_valid
      `TYPE_FETCH: hit_d = exec_valid && (exec_addr == lo);
      `TYPE_DATA: hit_d = bus_valid && addr_ok && dir_ok;
      `TYPE_IRQ: hit_d = (irq_enter && cfg[`CFG_IRQ_IN]) ||
                         (irq_return && cfg[`CFG_IRQ_OUT]);
      `TYPE_TRIG: hit_d = (trig_level == cfg[`CFG_TRIG_LVL]);
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hit_q <= 1'b0;
    else
      hit_q <= armed && cfg[`CFG_EN] && hit_d;
  end
endmodule

// >>> verilog/trans_mem.v
// State transition table with one write port and a registered read port
`timescale 1ns/100ps
`include "evt_consts.vh"
module trans_mem #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [`TR_W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [`TR_W-1:0] rdata_q
);
  reg [`TR_W-1:0] mem_q [0:DEPTH-1];
  integer i;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {`TR_W{1'b0}};
      rdata_q <= {`TR_W{1'b0}};
    end
    else
    begin
      if (we)
        mem_q[waddr] <= wdata;
      rdata_q <= mem_q[raddr];
    end
  end
endmodule

// >>> verilog/event_detector.v
// Event detection and combination with APB register access and interrupt
//
// Functional notes
// - Sixteen comparators, all armed together, any address
// - Combined condition drives halt, trace, performance outputs
// - Fetch event fires on executed programmed address
// - Prefetched but discarded fetches never match
// - Data event: address or range plus qualifiers
// - Interrupt event on entry and on return
// - Trigger event while sampled input matches level
// - Exactly one combination mode active at once
// - OR: any selected event fires
// - Accumulating AND: all selected seen, any order
// - Simultaneous AND: all selected in one cycle
// - Subroutine: selected event inside execution range
// - Sequential: events in programmed order, stepwise
// - State transitions: reach programmed final state
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "evt_consts.vh"
module event_detector #(
  parameter AW = 24,
  parameter NEV = 16,
  parameter NST = 8
) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire exec_valid,
  input wire [AW-1:0] exec_addr,
  input wire bus_valid,
  input wire bus_write,
  input wire [AW-1:0] bus_addr,
  input wire irq_enter,
  input wire irq_return,
  input wire trig_in,
  output reg halt_q,
  output reg trace_q,
  output reg perf_q,
  output reg cond_q,
  output reg irq_q
);
  reg rst_s1_q;
  reg rst_n_q;
  reg trig_s1_q;
  reg trig_s2_q;
  reg [`CTRL_W-1:0] ctrl_q;
  reg [NEV-1:0] sel_q;
  reg [17:0] seq_q;
  reg [AW-1:0] sub_lo_q;
  reg [AW-1:0] sub_hi_q;
  reg [3:0] idx_q;
  reg [`CFG_W-1:0] cfg_q [0:NEV-1];
  reg [AW-1:0] lo_q [0:NEV-1];
  reg [AW-1:0] hi_q [0:NEV-1];
  reg [NEV-1:0] acc_q;
  reg [1:0] step_q;
  reg seq_done_q;
  reg [2:0] state_q;
  reg in_sub_q;
  reg [`INT_W-1:0] int_st_q;
  reg [`INT_W-1:0] int_mask_q;
  reg [31:0] rd_d;
  reg rd_err_d;
  reg cond_d;
  reg [NEV-1:0] acc_d;
  reg [1:0] step_d;
  reg seq_done_d;
  reg [2:0] state_d;
  wire [NEV-1:0] hit;
  wire [`TR_W-1:0] ent;
  integer i;

  wire arm = ctrl_q[`CTRL_ARM];
  wire [2:0] mode = ctrl_q[`CTRL_MODE_LO+2:`CTRL_MODE_LO];
  wire [2:0] final_st = ctrl_q[`CTRL_FINAL_LO+2:`CTRL_FINAL_LO];
  wire acc_phase = psel && penable;
  wire wr = acc_phase && pready_q && pwrite;
  wire ctrl_wr = wr && (paddr == `A_CTRL);
  // Combination state is restarted whenever detection is disarmed or the control register is written
  wire clr = !arm || ctrl_wr;
  wire [NEV-1:0] hm = hit & sel_q;
  wire sel_any = |sel_q;

  function sel_bit;
    input [NEV-1:0] v;
    input [3:0] k;
    begin
      sel_bit = v[k];
    end
  endfunction

  // Reset release through two flops
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  always @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NEV; g = g + 1)
    begin : ev
      event_match #(.AW(AW)) u_match (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .armed(arm),
        .cfg(cfg_q[g]),
        .lo(lo_q[g]),
        .hi(hi_q[g]),
        .exec_valid(exec_valid),
        .exec_addr(exec_addr),
        .bus_valid(bus_valid),
        .bus_write(bus_write),
        .bus_addr(bus_addr),
        .irq_enter(irq_enter),
        .irq_return(irq_return),
        .trig_level(trig_s2_q),
        .hit_q(hit[g])
      );
    end
  endgenerate

  // Read address is the next state, so the entry always belongs to state_q
  trans_mem #(.DEPTH(NST), .AW(3)) u_trans (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .we(wr && (paddr == `A_TRANS)),
    .waddr(pwdata[`TR_STATE_LO+2:`TR_STATE_LO]),
    .wdata(pwdata[`TR_EN:`TR_EV_LO]),
    .raddr(state_d),
    .rdata_q(ent)
  );

  // Combination of the selected hits, or of the hit indexed by the sequence or transition entry, under the one active mode
  always @*
  begin
    acc_d = acc_q;
    step_d = step_q;
    seq_done_d = seq_done_q;
    state_d = state_q;
    cond_d = 1'b0;
    case (mode)
      `MODE_OR: cond_d = |hm;
      `MODE_ACC:
      begin
        acc_d = acc_q | hm;
        cond_d = sel_any && ((acc_d & sel_q) == sel_q);
      end
      `MODE_SIM: cond_d = sel_any && (hm == sel_q);
      `MODE_SUB: cond_d = in_sub_q && (|hm);
      `MODE_SEQ:
      begin
        if (!seq_done_q && sel_bit(hit, seq_q[step_q*4 +: 4]))
        begin
          if (step_q == seq_q[17:16])
            seq_done_d = 1'b1;
          else
            step_d = step_q + 2'd1;
        end
        cond_d = seq_done_d;
      end
      `MODE_FSM:
      begin
        if (ent[`TR_W-1] && sel_bit(hit, ent[3:0]))
          state_d = ent[6:4];
        cond_d = (state_d == final_st);
      end
      default: cond_d = 1'b0;
    endcase
    if (clr)
    begin
      acc_d = {NEV{1'b0}};
      step_d = 2'd0;
      seq_done_d = 1'b0;
      state_d = 3'd0;
      cond_d = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      acc_q <= {NEV{1'b0}};
      step_q <= 2'd0;
      seq_done_q <= 1'b0;
      state_q <= 3'd0;
      in_sub_q <= 1'b0;
      cond_q <= 1'b0;
      halt_q <= 1'b0;
      trace_q <= 1'b0;
      perf_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      step_q <= step_d;
      seq_done_q <= seq_done_d;
      state_q <= state_d;
      if (exec_valid)
        in_sub_q <= (exec_addr >= sub_lo_q) && (exec_addr <= sub_hi_q);
      cond_q <= cond_d;
      halt_q <= cond_d && ctrl_q[`CTRL_HALT];
      trace_q <= cond_d && ctrl_q[`CTRL_TRACE];
      perf_q <= cond_d && ctrl_q[`CTRL_PERF];
    end
  end

  // Register read mux
  always @*
  begin
    rd_d = 32'h00000000;
    rd_err_d = 1'b0;
    case (paddr)
      `A_CTRL: rd_d[`CTRL_W-1:0] = ctrl_q;
      `A_SEL: rd_d[NEV-1:0] = sel_q;
      `A_SEQ: rd_d[17:0] = seq_q;
      `A_SUB_LO: rd_d[AW-1:0] = sub_lo_q;
      `A_SUB_HI: rd_d[AW-1:0] = sub_hi_q;
      `A_EV_IDX: rd_d[3:0] = idx_q;
      `A_EV_CFG: rd_d[`CFG_W-1:0] = cfg_q[idx_q];
      `A_EV_LO: rd_d[AW-1:0] = lo_q[idx_q];
      `A_EV_HI: rd_d[AW-1:0] = hi_q[idx_q];
      `A_HITS: rd_d[NEV-1:0] = (mode == `MODE_ACC) ? acc_q : hit;
      `A_STAT: rd_d[7:0] = {seq_done_q, step_q, state_q, in_sub_q, cond_q};
      `A_INT_ST: rd_d[`INT_W-1:0] = int_st_q;
      `A_INT_MASK: rd_d[`INT_W-1:0] = int_mask_q;
      `A_TRANS: rd_d = 32'h00000000;
      default: rd_err_d = 1'b1;
    endcase
  end

  // APB slave: one wait state, answer on the second access cycle
  always @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ctrl_q <= `CTRL_RST;
      sel_q <= {NEV{1'b0}};
      seq_q <= 18'h00000;
      sub_lo_q <= {AW{1'b0}};
      sub_hi_q <= {AW{1'b0}};
      idx_q <= 4'h0;
      int_mask_q <= {`INT_W{1'b0}};
      for (i = 0; i < NEV; i = i + 1)
      begin
        cfg_q[i] <= {`CFG_W{1'b0}};
        lo_q[i] <= {AW{1'b0}};
        hi_q[i] <= {AW{1'b0}};
      end
    end
    else
    begin
      pready_q <= acc_phase && !pready_q;
      // Error flag stands only with the ready pulse
      pslverr_q <= acc_phase && !pready_q && rd_err_d;
      if (acc_phase && !pready_q)
        prdata_q <= pwrite ? 32'h00000000 : rd_d;
      if (wr)
      begin
        case (paddr)
          `A_CTRL: ctrl_q <= pwdata[`CTRL_W-1:0];
          `A_SEL: sel_q <= pwdata[NEV-1:0];
          `A_SEQ: seq_q <= pwdata[17:0];
          `A_SUB_LO: sub_lo_q <= pwdata[AW-1:0];
          `A_SUB_HI: sub_hi_q <= pwdata[AW-1:0];
          `A_EV_IDX: idx_q <= pwdata[3:0];
          `A_EV_CFG: cfg_q[idx_q] <= pwdata[`CFG_W-1:0];
          `A_EV_LO: lo_q[idx_q] <= pwdata[AW-1:0];
          `A_EV_HI: hi_q[idx_q] <= pwdata[AW-1:0];
          `A_INT_MASK: int_mask_q <= pwdata[`INT_W-1:0];
          default: idx_q <= idx_q;
        endcase
      end
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear
  always @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      int_st_q <= {`INT_W{1'b0}};
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr && (paddr == `A_INT_ST))
        int_st_q <= (int_st_q & ~pwdata[`INT_W-1:0]) | {|hm, cond_d && !cond_q};
      else
        int_st_q <= int_st_q | {|hm, cond_d && !cond_q};
      irq_q <= |(int_st_q & int_mask_q);
    end
  end
endmodule

// >>> testbench/event_detector_monitor.sv
// Concurrent checks on the event detector ports
`timescale 1ns/100ps
module event_detector_monitor (
  input logic clk_sys,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata_q,
  input logic pready_q,
  input logic pslverr_q,
  input logic halt_q,
  input logic trace_q,
  input logic perf_q,
  input logic cond_q,
  input logic irq_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && !pready_q ##1 pready_q;
  endsequence
  property p_one_wait;
    s_setup |=> s_answer;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("ready not in second access cycle");
  property p_ready_access;
    pready_q |-> psel && penable && $past(penable);
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("ready outside access phase");
  property p_err_ready;
    pslverr_q |-> pready_q;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_wr_zero;
    pready_q && pwrite |-> prdata_q == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("read data not zero on write");
  property p_err_zero;
    pslverr_q && !pwrite |-> prdata_q == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  property p_halt;
    halt_q |-> cond_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt without condition");
  property p_trace_perf;
    trace_q || perf_q |-> cond_q;
  endproperty
  a_trace_perf: assert property (p_trace_perf)
    else $error("trace or perf without condition");
  property p_reset_quiet;
    $rose(resetn) |-> (!cond_q && !irq_q && !pready_q)[*2];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
endmodule
bind event_detector event_detector_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .halt_q(halt_q), .trace_q(trace_q),
  .perf_q(perf_q), .cond_q(cond_q), .irq_q(irq_q));

// >>> testbench/core_model.sv
// Behavioural model of the target core execution and bus status
`timescale 1ns/100ps
module core_model (
  input logic clk_sys,
  output logic exec_valid,
  output logic [23:0] exec_addr,
  output logic bus_valid,
  output logic bus_write,
  output logic [23:0] bus_addr,
  output logic irq_enter,
  output logic irq_return,
  output logic trig_in
);
  initial
  begin
    {exec_valid, exec_addr, bus_valid, bus_write, bus_addr} = 51'h0;
    {irq_enter, irq_return, trig_in} = 3'h0;
  end
  // Bit 0 execute, 1 read, 2 write, 3 interrupt return, 4 entry
  task act(input logic [4:0] w, input logic [23:0] fa, input logic [23:0] da);
    @(posedge clk_sys);
    exec_valid <= w[0];
    {exec_addr, bus_addr} <= {fa, da};
    {bus_valid, bus_write} <= {w[1] | w[2], w[2]};
    {irq_enter, irq_return} <= w[4:3];
    @(posedge clk_sys);
    {exec_valid, bus_valid, irq_enter, irq_return} <= 4'h0;
    // Released address lines must not keep the last value
    {exec_addr, bus_addr, bus_write} <= {~fa, ~da, ~w[2]};
  endtask
  task trig(input logic l);
    @(posedge clk_sys);
    trig_in <= l;
  endtask
endmodule

// >>> testbench/tb_event_detector.sv
// Self-checking bench for the event detector
`timescale 1ns/100ps
`include "evt_consts.vh"
module tb_event_detector;
  localparam logic [23:0] FA = 24'h001000;
  localparam logic [23:0] DA = 24'h002000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic er;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, halt_q, trace_q, perf_q, cond_q, irq_q;
  wire ev, bv, bw, ie, ir, tr;
  wire [23:0] ea, ba;
  integer miscompares = 0;
  integer num_checks = 0;
  event_detector u_event_detector (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .exec_valid(ev),
    .exec_addr(ea), .bus_valid(bv), .bus_write(bw), .bus_addr(ba), .irq_enter(ie),
    .irq_return(ir), .trig_in(tr), .halt_q(halt_q), .trace_q(trace_q), .perf_q(perf_q),
    .cond_q(cond_q), .irq_q(irq_q));
  core_model u_core_model (.clk_sys(clk_sys), .exec_valid(ev), .exec_addr(ea),
    .bus_valid(bv), .bus_write(bw), .bus_addr(ba), .irq_enter(ie), .irq_return(ir),
    .trig_in(tr));
  initial forever #12.5 clk_sys = ~clk_sys;
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready_q !== 1'b1)
      @(posedge clk_sys);
    {rd, er} = {prdata_q, pslverr_q};
    {psel, penable} <= 2'h0;
  endtask
  task ec(input integer d, input logic e);
    repeat (d) @(posedge clk_sys);
    #1;
    chk("cond", {28'h0, {4{e}}}, {28'h0, cond_q, halt_q, trace_q, perf_q});
  endtask
  task ei(input integer d, input logic e);
    repeat (d) @(posedge clk_sys);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq_q});
  endtask
  task cfg(input logic [3:0] i, input logic [8:0] c, input logic [23:0] lo);
    apb(1'b1, `A_EV_IDX, {28'h0, i});
    apb(1'b1, `A_EV_CFG, {23'h0, c});
    apb(1'b1, `A_EV_LO, {8'h0, lo});
    apb(1'b1, `A_EV_HI, {8'h0, lo + 24'hFF});
  endtask
  task arm(input logic [2:0] m, input logic [2:0] f, input logic [15:0] s,
    input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, `A_CTRL, 32'h0);
    apb(1'b1, a, d);
    apb(1'b1, `A_SEL, {16'h0, s});
    apb(1'b1, `A_CTRL, {22'h0, 3'h7, f, m, 1'b1});
  endtask
  task t_regs;
    apb(1'b1, `A_SEL, 32'h0000A5A5);
    apb(1'b0, `A_SEL, 32'h0);
    chk("sel", 32'h0000A5A5, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h00000001, {rd[30:0], er});
  endtask
  task t_or;
    arm(`MODE_OR, 3'h0, 16'h0003, `A_SEQ, 32'h0);
    u_core_model.act(5'h00, FA, DA);
    ec(1, 1'b0);
    u_core_model.act(5'h01, FA + 24'h2, DA);
    ec(1, 1'b0);
    u_core_model.act(5'h01, FA, DA);
    ec(1, 1'b1);
    u_core_model.act(5'h02, FA, DA + 24'hFF);
    ec(1, 1'b1);
    u_core_model.act(5'h04, FA, DA + 24'h10);
    ec(1, 1'b0);
    u_core_model.act(5'h02, FA, DA + 24'h100);
    ec(1, 1'b0);
  endtask
  task t_modes;
    arm(`MODE_ACC, 3'h0, 16'h0003, `A_SEQ, 32'h0);
    u_core_model.act(5'h01, FA, DA);
    ec(2, 1'b0);
    u_core_model.act(5'h02, FA, DA);
    ec(4, 1'b1);
    apb(1'b1, `A_CTRL, 32'h00000383);
    ec(2, 1'b0);
    arm(`MODE_SIM, 3'h0, 16'h0003, `A_SEQ, 32'h0);
    u_core_model.act(5'h01, FA, DA);
    ec(1, 1'b0);
    u_core_model.act(5'h03, FA, DA);
    ec(1, 1'b1);
    arm(`MODE_SEQ, 3'h0, 16'h0003, `A_SEQ, 32'h00010001);
    u_core_model.act(5'h01, FA, DA);
    u_core_model.act(5'h02, FA, DA);
    ec(2, 1'b0);
    u_core_model.act(5'h01, FA, DA);
    ec(4, 1'b1);
    arm(`MODE_FSM, 3'h1, 16'h0003, `A_TRANS, 32'h00000480);
    u_core_model.act(5'h02, FA, DA);
    ec(2, 1'b0);
    u_core_model.act(5'h01, FA, DA);
    ec(4, 1'b1);
  endtask
  task t_irq;
    arm(`MODE_OR, 3'h0, 16'h0004, `A_INT_MASK, 32'h1);
    apb(1'b1, `A_INT_ST, 32'h3);
    ei(1, 1'b0);
    u_core_model.act(5'h08, FA, DA);
    ec(1, 1'b1);
    ei(1, 1'b1);
    apb(1'b1, `A_INT_ST, 32'h1);
    ei(1, 1'b0);
    apb(1'b1, `A_INT_MASK, 32'h0);
    u_core_model.act(5'h10, FA, DA);
    ec(1, 1'b1);
    ei(3, 1'b0);
    apb(1'b1, `A_INT_MASK, 32'h1);
    ei(2, 1'b1);
  endtask
  task t_trig;
    arm(`MODE_OR, 3'h0, 16'h8000, `A_SEQ, 32'h0);
    u_core_model.trig(1'b1);
    ec(4, 1'b1);
    u_core_model.trig(1'b0);
    ec(4, 1'b0);
  endtask
  task t_sub;
    apb(1'b1, `A_CTRL, 32'h0);
    apb(1'b1, `A_SUB_HI, {8'h0, FA + 24'h10});
    arm(`MODE_SUB, 3'h0, 16'h0002, `A_SUB_LO, {8'h0, FA});
    u_core_model.act(5'h02, FA, DA);
    ec(1, 1'b0);
    u_core_model.act(5'h03, FA + 24'h4, DA);
    ec(1, 1'b1);
    u_core_model.act(5'h01, FA + 24'h20, DA);
    u_core_model.act(5'h02, FA, DA);
    ec(1, 1'b0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    cfg(4'h0, 9'h100, FA);
    cfg(4'h1, 9'h10D, DA);
    cfg(4'h2, 9'h162, 24'h0);
    cfg(4'hF, 9'h183, 24'h0);
    t_or;
    t_modes;
    t_irq;
    t_trig;
    t_sub;
    stop_test;
  end
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    miscompares++;
    stop_test;
  end
endmodule
